// file: dmicfe_top.sv
// digital microphone capture front end with ahb-lite registers
// assumes mic data pin is asynchronous and the sample sink
// on the serial audio side takes words with valid and ready
module dmicfe_top
  import dmicfe_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  // microphone pins
  output      logic        mic_clock_out_pin,
  output      logic        mic_clock_out_oe,
  input  wire logic        mic_data_in_pin,
  // analog adc permission toward the analog front end
  output      logic        adc_analog_en,
  // decimated words toward the audio serial bus
  output      logic [31:0] sample_data,
  output      logic        sample_valid,
  input  wire logic        sample_ready
);

  initial begin
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64)
      $error("dmicfe_top: fifo depth out of range 2..64");
  end

  localparam int LW = $clog2(FIFO_DEPTH + 1) + 1;  // fifo level width

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [DMICFE_CTRL_W-1:0] ctrl_q;     // control register
  logic [7:0]  clkdiv_q;                // mic clock half period
  logic        ovf_q;                   // sticky overflow
  logic [31:0] last_word_q;             // last decimated word
  logic [31:0] hrdata_q;                // registered read data
  logic        wr_pend_q;               // write data phase pending
  logic [3:0]  wr_addr_q;               // latched write offset
  logic        adc_analog_en_q;         // analog conversion allowed

  // mic clock and capture state
  logic [7:0]  div_cnt_q;               // half period counter
  logic        mclk_q;                  // generated mic clock
  logic        mclk_oe_q;               // pin driven while enabled
  logic        din_s1_q;                // synchroniser first stage
  logic        din_s2_q;                // synchroniser second stage
  logic [7:0]  bit_cnt_q;               // clocks in current frame
  logic [7:0]  ones_l_q;                // left ones in frame
  logic [7:0]  ones_r_q;                // right ones in frame
  logic [31:0] push_data_q;             // word waiting for the fifo
  logic        push_valid_q;            // word waiting flag

  ////////////////////////////////////////////////////////////////////////////
  // control field decode
  wire       mode_en  = ctrl_q[DMICFE_CTRL_EN];
  wire [1:0] osr_sel  = ctrl_q[DMICFE_CTRL_OSR_LO +: 2];
  wire       left_en  = ctrl_q[DMICFE_CTRL_LEFT];
  wire       right_en = ctrl_q[DMICFE_CTRL_RIGHT];

  // ratio and scale from the select, unused code falls back to 128
  wire [7:0] ratio = (osr_sel == DMICFE_OSR_64) ? DMICFE_RATIO_64 :
                     (osr_sel == DMICFE_OSR_32) ? DMICFE_RATIO_32 :
                     DMICFE_RATIO_128;
  wire [3:0] shift = (osr_sel == DMICFE_OSR_64) ? DMICFE_SHIFT_64 :
                     (osr_sel == DMICFE_OSR_32) ? DMICFE_SHIFT_32 :
                     DMICFE_SHIFT_128;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite decode
  wire       bus_act  = hsel && hready && htrans[1];  // nonseq or seq
  wire       rd_req   = bus_act && !hwrite;
  wire       wr_req   = bus_act && hwrite;
  wire [3:0] req_off  = {haddr[3:2], 2'b00};
  wire       in_range = (haddr[31:4] == 28'h000_0000);
  wire       wr_ctrl  = wr_pend_q && (wr_addr_q == DMICFE_OFF_CTRL);
  wire       wr_div   = wr_pend_q && (wr_addr_q == DMICFE_OFF_CLKDIV);
  wire       wr_stat  = wr_pend_q && (wr_addr_q == DMICFE_OFF_STATUS);
  wire [7:0] div_new  = (hwdata[7:0] < DMICFE_CLKDIV_MIN) ?
                        DMICFE_CLKDIV_MIN : hwdata[7:0];

  // fifo status for readback
  wire [LW-1:0] fifo_level;
  wire          fifo_in_ready;

  wire [31:0] status_word = {16'h0000,
                             8'(fifo_level),
                             6'h00, ovf_q, mclk_oe_q};
  wire [31:0] rd_mux =
    !in_range                        ? 32'h0000_0000 :
    (req_off == DMICFE_OFF_CTRL)     ? 32'(ctrl_q) :
    (req_off == DMICFE_OFF_CLKDIV)   ? 32'(clkdiv_q) :
    (req_off == DMICFE_OFF_STATUS)   ? status_word :
    (req_off == DMICFE_OFF_SAMPLE)   ? last_word_q :
    32'h0000_0000;

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;   // constant okay, zero wait states
  assign hresp     = 1'b0;   // okay only

  ////////////////////////////////////////////////////////////////////////////
  // address phase capture and read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 4'h0;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_req && in_range;
      wr_addr_q <= req_off;
      if (rd_req)
        hrdata_q <= rd_mux;
    end
  end

  // writable registers, data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= DMICFE_CTRL_RST;
      clkdiv_q <= DMICFE_CLKDIV_RST;
    end else begin
      if (wr_ctrl)
        ctrl_q <= hwdata[DMICFE_CTRL_W-1:0];
      if (wr_div)
        clkdiv_q <= div_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog conversion is locked out while mic mode runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      adc_analog_en_q <= 1'b0;
    else
      adc_analog_en_q <= ctrl_q[DMICFE_CTRL_ANALOG] && !mode_en;
  end
  assign adc_analog_en = adc_analog_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // mic clock generator, divided from hclk
  wire div_wrap = (div_cnt_q >= clkdiv_q - 8'h01);
  wire rise_evt = mode_en && div_wrap && !mclk_q;  // clock goes high
  wire fall_evt = mode_en && div_wrap && mclk_q;   // clock goes low

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 8'h00;
      mclk_q    <= 1'b0;
      mclk_oe_q <= 1'b0;
    end else if (!mode_en) begin
      // stopped clock rests low
      div_cnt_q <= 8'h00;
      mclk_q    <= 1'b0;
      mclk_oe_q <= 1'b0;
    end else begin
      mclk_oe_q <= 1'b1;
      if (div_wrap) begin
        div_cnt_q <= 8'h00;
        mclk_q    <= !mclk_q;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
    end
  end
  assign mic_clock_out_pin = mclk_q;
  assign mic_clock_out_oe  = mclk_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // data pin synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end else begin
      din_s1_q <= mic_data_in_pin;
      din_s2_q <= din_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture and boxcar decimation
  wire last_bit = rise_evt && (bit_cnt_q >= ratio - 8'h01);
  wire cap_l    = rise_evt && left_en && din_s2_q;
  wire cap_r    = fall_evt && right_en && din_s2_q;

  // ones to signed pcm: 2*ones - ratio, then scaled
  wire [15:0] pcm_l_raw = {7'h00, ones_l_q, 1'b0} +
                          16'(cap_l) + 16'(cap_l) - 16'(ratio);
  wire [15:0] pcm_r_raw = {7'h00, ones_r_q, 1'b0} - 16'(ratio);
  wire [15:0] pcm_l = left_en  ? 16'(pcm_l_raw << shift) : 16'h0000;
  wire [15:0] pcm_r = right_en ? 16'(pcm_r_raw << shift) : 16'h0000;

  // frame counters; edge choice is per channel enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt_q <= 8'h00;
      ones_l_q  <= 8'h00;
      ones_r_q  <= 8'h00;
    end else if (!mode_en) begin
      bit_cnt_q <= 8'h00;
      ones_l_q  <= 8'h00;
      ones_r_q  <= 8'h00;
    end else if (last_bit) begin
      // right half of last clock falls into next frame
      bit_cnt_q <= 8'h00;
      ones_l_q  <= 8'h00;
      ones_r_q  <= 8'h00;
    end else begin
      if (rise_evt)
        bit_cnt_q <= bit_cnt_q + 8'h01;
      if (cap_l)
        ones_l_q <= ones_l_q + 8'h01;
      if (cap_r)
        ones_r_q <= ones_r_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word hand-off into the fifo; a word not taken before the next
  // frame ends is overwritten and flagged
  wire new_word = last_bit && (left_en || right_en);
  wire push_ok  = push_valid_q && fifo_in_ready;
  wire ovf_set  = new_word && push_valid_q && !fifo_in_ready;
  wire ovf_clr  = wr_stat && hwdata[DMICFE_ST_OVF];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      push_data_q  <= 32'h0000_0000;
      push_valid_q <= 1'b0;
      last_word_q  <= 32'h0000_0000;
    end else begin
      if (new_word) begin
        push_data_q  <= {pcm_l, pcm_r};
        push_valid_q <= 1'b1;
        last_word_q  <= {pcm_l, pcm_r};
      end else if (push_ok) begin
        push_valid_q <= 1'b0;
      end
    end
  end

  // sticky overflow, set wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ovf_q <= 1'b0;
    else if (ovf_set)
      ovf_q <= 1'b1;
    else if (ovf_clr)
      ovf_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample fifo toward the serial audio bus
  dmicfe_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_data   (push_data_q),
    .in_valid  (push_valid_q),
    .in_ready  (fifo_in_ready),
    .out_data  (sample_data),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .level     (fifo_level)
  );

endmodule

// file: dmicfe_pkg.sv
// constants shared by the digital microphone capture front end
// assumes an ahb-lite register bus and a single hclk domain
package dmicfe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [3:0] DMICFE_OFF_CTRL   = 4'h0;  // control
  localparam logic [3:0] DMICFE_OFF_CLKDIV = 4'h4;  // half period of mic clock
  localparam logic [3:0] DMICFE_OFF_STATUS = 4'h8;  // status, w1c overflow
  localparam logic [3:0] DMICFE_OFF_SAMPLE = 4'hC;  // last decimated word

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int DMICFE_CTRL_EN      = 0;  // digital mic mode enable
  localparam int DMICFE_CTRL_OSR_LO  = 1;  // ratio select, two bits
  localparam int DMICFE_CTRL_LEFT    = 3;  // left channel (rising edge)
  localparam int DMICFE_CTRL_RIGHT   = 4;  // right channel (falling edge)
  localparam int DMICFE_CTRL_ANALOG  = 5;  // analog adc request
  localparam int DMICFE_CTRL_W       = 6;  // implemented control bits
  localparam logic [5:0] DMICFE_CTRL_RST = 6'h00;

  // status register fields
  localparam int DMICFE_ST_RUN   = 0;  // mic clock running
  localparam int DMICFE_ST_OVF   = 1;  // sticky overflow, write one clears
  localparam int DMICFE_ST_LVL   = 8;  // fifo level, low bit

  ////////////////////////////////////////////////////////////////////////////
  // oversampling ratio encodings
  localparam logic [1:0] DMICFE_OSR_128 = 2'h0;
  localparam logic [1:0] DMICFE_OSR_64  = 2'h1;
  localparam logic [1:0] DMICFE_OSR_32  = 2'h2;
  localparam logic [7:0] DMICFE_RATIO_128 = 8'h80;
  localparam logic [7:0] DMICFE_RATIO_64  = 8'h40;
  localparam logic [7:0] DMICFE_RATIO_32  = 8'h20;
  // left shift that brings each pcm value to common scale
  localparam logic [3:0] DMICFE_SHIFT_128 = 4'h7;
  localparam logic [3:0] DMICFE_SHIFT_64  = 4'h8;
  localparam logic [3:0] DMICFE_SHIFT_32  = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int HCLK_PERIOD_NS   = 100;  // 10 MHz bus clock
  localparam int MIC_CLK_PERIOD_NS = 800; // default mic clock period
  // half period in hclk cycles, rounded down so the clock is never slow
  localparam int MIC_HALF_CYC = MIC_CLK_PERIOD_NS / (2 * HCLK_PERIOD_NS);
  localparam logic [7:0] DMICFE_CLKDIV_RST = 8'(MIC_HALF_CYC);
  // data pin passes two flops, so a half period needs at least three
  localparam logic [7:0] DMICFE_CLKDIV_MIN = 8'h03;

  // ahb-lite encodings
  localparam logic [1:0] DMICFE_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DMICFE_HTRANS_SEQ    = 2'h3;

endpackage

// file: dmicfe_fifo.sv
// small fifo holding decimated sample words
// assumes one clock; read data comes out of a register
module dmicfe_fifo
  import dmicfe_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic [WIDTH-1:0]           in_data,
  input  wire logic                       in_valid,
  output      logic                       in_ready,
  output      logic [WIDTH-1:0]           out_data,
  output      logic                       out_valid,
  input  wire logic                       out_ready,
  output      logic [$clog2(DEPTH+1):0]   level
);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("dmicfe_fifo: depth must be a power of two, at least 2");
  end

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];   // storage array
  logic [AW-1:0]    wr_ptr_q;        // write index
  logic [AW-1:0]    rd_ptr_q;        // read index
  logic [CW-1:0]    cnt_q;           // words in array
  logic [WIDTH-1:0] out_data_q;      // registered head word
  logic             out_valid_q;     // head word present

  ////////////////////////////////////////////////////////////////////////////
  // handshake decode
  wire do_push = in_valid && in_ready;                  // word accepted
  wire do_load = (cnt_q != '0) && (!out_valid_q || out_ready); // refill head
  wire do_drop = out_valid_q && out_ready && !do_load;  // head leaves empty

  // full counts the head word too, so DEPTH words are held in all
  assign in_ready  = (level != (CW+1)'(DEPTH));
  assign out_data  = out_data_q;
  assign out_valid = out_valid_q;
  assign level     = (CW+1)'(cnt_q) + (CW+1)'(out_valid_q);

  ////////////////////////////////////////////////////////////////////////////
  // array write, no reset needed on data
  always_ff @(posedge hclk) begin
    if (do_push)
      mem_q[wr_ptr_q] <= in_data;
  end

  // pointers and count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (do_push)
        wr_ptr_q <= wr_ptr_q + AW'(1);
      if (do_load)
        rd_ptr_q <= rd_ptr_q + AW'(1);
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_load);
    end
  end

  // output register stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_data_q  <= '0;
      out_valid_q <= 1'b0;
    end else if (do_load) begin
      out_data_q  <= mem_q[rd_ptr_q];
      out_valid_q <= 1'b1;
    end else if (do_drop) begin
      out_valid_q <= 1'b0;
    end
  end

endmodule

// file: dmicfe_top_asserts.sv
// assertions for the mic capture front end, bound to dmicfe_top
// assumes one hclk domain and whole word bus writes
module dmicfe_top_asserts
  import dmicfe_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        mic_clock_out_pin,
  input wire logic        mic_clock_out_oe,
  input wire logic        adc_analog_en,
  input wire logic [31:0] sample_data,
  input wire logic        sample_valid,
  input wire logic        sample_ready
);
  logic       wr_q;    // write data phase pending
  logic [1:0] off_q;   // offset of that write
  logic [5:0] ctl_q;   // control mirror
  logic [7:0] div_q;   // half period mirror
  logic       pin_q;   // clock pin one cycle ago
  logic [8:0] hc_q;    // cycles since last toggle
  logic       seen_q;  // a toggle seen in this run
  wire        take_w = hsel && hready && htrans[1] && haddr[31:4] == 28'h0;
  wire        tog_w  = mic_clock_out_pin != pin_q;
  wire  [7:0] div_w  = (hwdata[7:0] < DMICFE_CLKDIV_MIN) ?
                       DMICFE_CLKDIV_MIN : hwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // mirror of control and divider writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      off_q <= 2'h0;
      ctl_q <= DMICFE_CTRL_RST;
      div_q <= DMICFE_CLKDIV_RST;
    end else begin
      wr_q  <= take_w && hwrite;
      off_q <= haddr[3:2];
      if (wr_q && off_q == 2'h0) ctl_q <= hwdata[5:0];
      if (wr_q && off_q == 2'h1) div_q <= div_w;
    end
  end

  // cycles between mic clock toggles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q  <= 1'b0;
      hc_q   <= 9'h001;
      seen_q <= 1'b0;
    end else begin
      pin_q  <= mic_clock_out_pin;
      hc_q   <= (tog_w || !mic_clock_out_oe) ? 9'h001 : hc_q + 9'h001;
      seen_q <= mic_clock_out_oe && ctl_q[0] && (seen_q || tog_w);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_clk_idle_low: assert property (
    !mic_clock_out_oe |-> !mic_clock_out_pin)
    else $error("mic clock high while not driven");
  a_oe_on_enable: assert property (
    $rose(ctl_q[0]) |-> ##[0:2] mic_clock_out_oe)
    else $error("clock pin not driven after enable");
  a_oe_off_disable: assert property (
    $fell(ctl_q[0]) |-> ##[0:2] !mic_clock_out_oe)
    else $error("clock pin still driven after disable");
  a_clk_stops_low: assert property (
    $fell(ctl_q[0]) |-> ##[0:2] (!mic_clock_out_pin) [*2])
    else $error("mic clock not stopped low");
  a_half_period: assert property (
    (mic_clock_out_oe && ctl_q[0] && seen_q && tog_w) |->
      hc_q == {1'b0, div_q})
    else $error("mic clock half period wrong");
  a_analog_blocked: assert property (
    (ctl_q[0] && $past(ctl_q[0])) |-> !adc_analog_en)
    else $error("analog adc enabled in mic mode");
  a_analog_allowed: assert property (
    (ctl_q[5] && !ctl_q[0]) [*2] |-> adc_analog_en)
    else $error("analog adc not enabled when requested");
  a_word_held: assert property (
    (sample_valid && !sample_ready) |=>
      (sample_valid && $stable(sample_data)))
    else $error("sample word dropped before accept");
endmodule

// file: dmicfe_mic_model.sv
// behavioural pair of digital microphones on one shared data line
// assumes the mic clock comes from the front end; hclk finds its edges
module dmicfe_mic_model (
  input  wire logic hclk,
  input  wire logic mic_clk,
  input  wire logic mic_oe,
  input  wire logic left_on,
  input  wire logic right_on,
  input  wire logic left_bit,
  input  wire logic right_bit,
  output      logic data
);
  logic clk_q;  // mic clock one hclk ago

  initial begin
    data  = 1'b0;
    clk_q = 1'b0;
  end

  // left mic drives the low half, right mic the high half
  always @(posedge hclk) begin
    clk_q <= mic_clk;
    if (!mic_oe) begin
      data <= ~data;  // no clock, line floats
    end else if (!mic_clk && clk_q) begin
      data <= left_on ? left_bit : ~data;
    end else if (mic_clk && !clk_q) begin
      data <= right_on ? right_bit : ~data;
    end else if (mic_clk ? !right_on : !left_on) begin
      data <= ~data;  // nobody drives this half
    end
  end
endmodule

// file: dmicfe_tb_top.sv
// self-checking bench for the mic capture front end
// assumes a zero wait ahb-lite slave and one bus master here
`define CHK(nm, ex, gt) \
  begin \
    checked++; \
    if ((gt) !== (ex)) begin \
      miscompares++; \
      $display("[ERR] %s exp %0h got %0h", nm, ex, gt); \
    end \
  end

module dmicfe_tb_top
  import dmicfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_CTL = {28'h0, DMICFE_OFF_CTRL};
  localparam logic [31:0] A_DIV = {28'h0, DMICFE_OFF_CLKDIV};
  localparam logic [31:0] A_ST  = {28'h0, DMICFE_OFF_STATUS};
  localparam logic [31:0] A_SMP = {28'h0, DMICFE_OFF_SAMPLE};

  typedef struct packed {
    logic [1:0]  osr;
    logic        lft;
    logic        rgt;
    logic        lb;
    logic        rb;
    logic [7:0]  ratio;
    logic [31:0] word;
  } dmicfe_row_t;

  // ratio, channels, mic bits and the steady word they give
  dmicfe_row_t rows [5] = '{
    '{DMICFE_OSR_128, 1'b1, 1'b1, 1'b1, 1'b0, DMICFE_RATIO_128, 32'h4000_C000},
    '{DMICFE_OSR_64, 1'b1, 1'b0, 1'b1, 1'b1, DMICFE_RATIO_64, 32'h4000_0000},
    '{DMICFE_OSR_32, 1'b0, 1'b1, 1'b0, 1'b1, DMICFE_RATIO_32, 32'h0000_4000},
    '{2'h3, 1'b1, 1'b1, 1'b0, 1'b1, DMICFE_RATIO_128, 32'hC000_4000},
    '{DMICFE_OSR_32, 1'b1, 1'b1, 1'b0, 1'b0, DMICFE_RATIO_32, 32'hC000_C000}
  };
  logic [31:0] ra [5] = '{A_CTL, A_DIV, A_ST, A_SMP, 32'h0000_0010};
  logic [31:0] re [5] = '{32'h0, 32'h0000_0004, 32'h0, 32'h0, 32'h0};

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, sample_data;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        mic_clock_out_pin, mic_clock_out_oe, mic_data_in_pin;
  logic        adc_analog_en, sample_valid, sample_ready;
  logic        l_on, r_on, l_bit, r_bit;  // model mic settings
  logic [31:0] rd;                         // last bus read
  int          miscompares = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;

  dmicfe_top #(.FIFO_DEPTH(8)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mic_clock_out_pin(mic_clock_out_pin),
    .mic_clock_out_oe(mic_clock_out_oe), .mic_data_in_pin(mic_data_in_pin),
    .adc_analog_en(adc_analog_en), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready));

  dmicfe_mic_model mics (
    .hclk(hclk), .mic_clk(mic_clock_out_pin), .mic_oe(mic_clock_out_oe),
    .left_on(l_on), .right_on(r_on), .left_bit(l_bit), .right_bit(r_bit),
    .data(mic_data_in_pin));

  ////////////////////////////////////////////////////////////////////////////
  // clock and cycle count
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;

  // one single ahb-lite transfer, held until hready
  task bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= DMICFE_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // next word accepted by the sink, with its cycle
  task take(output logic [31:0] w, output int t);
    do @(posedge hclk); while (!(sample_valid === 1'b1 && sample_ready));
    w = sample_data;
    t = cyc;
  endtask

  // one table row: steady word, word spacing, sample register
  task run_row(input dmicfe_row_t rw);
    logic [31:0] w;
    int          t0;
    int          t1;
    l_on <= rw.lft;
    r_on <= rw.rgt;
    l_bit <= rw.lb;
    r_bit <= rw.rb;
    sample_ready <= 1'b1;
    bus(1'b1, A_CTL, {27'h0, rw.rgt, rw.lft, rw.osr, 1'b1}, rd);
    take(w, t0);  // first word may hold a partial half
    take(w, t0);
    `CHK("word", rw.word, w)
    take(w, t1);
    `CHK("gap", {21'h0, rw.ratio, 3'h0}, 32'(t1 - t0))
    bus(1'b0, A_SMP, 32'h0, rd);
    `CHK("sample reg", rw.word, rd)
    bus(1'b0, A_ST, 32'h0, rd);
    `CHK("running", 1'b1, rd[0])
    bus(1'b1, A_CTL, 32'h0, rd);
    repeat (20) @(posedge hclk);
  endtask

  task summarize;
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge hclk);
    miscompares++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sample_ready = 1'b0;
    {l_on, r_on, l_bit, r_bit} = 4'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    // too short a half period is raised to the minimum
    bus(1'b1, A_DIV, 32'h0000_0001, rd);
    bus(1'b0, A_DIV, 32'h0, rd);
    `CHK("clkdiv", 32'h0000_0003, rd)
    bus(1'b1, A_DIV, 32'h0000_0004, rd);
    // analog request honoured only with mic mode off
    sample_ready <= 1'b0;
    l_on <= 1'b1;
    bus(1'b1, A_CTL, 32'h0000_0020, rd);
    repeat (3) @(posedge hclk);
    `CHK("analog", 1'b1, adc_analog_en)
    bus(1'b1, A_CTL, 32'h0000_002D, rd);
    repeat (3) @(posedge hclk);
    `CHK("analog", 1'b0, adc_analog_en)
    // stalled sink: fifo fills and a word is lost
    repeat (2600) @(posedge hclk);
    bus(1'b0, A_ST, 32'h0, rd);
    `CHK("status full", 16'h0803, rd[15:0])
    bus(1'b1, A_CTL, 32'h0, rd);
    bus(1'b1, A_ST, 32'h0000_0002, rd);
    bus(1'b0, A_ST, 32'h0, rd);
    `CHK("status clr", 16'h0800, rd[15:0])
    sample_ready <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge hclk);
      if (sample_valid === 1'b1 && sample_ready) n++;
    end
    // eight words in the fifo plus the one held at its input
    `CHK("drained", 9, n)
    // both channels off: no word forms
    l_on <= 1'b0;
    bus(1'b1, A_CTL, 32'h0000_0005, rd);
    n = 0;
    repeat (600) begin
      @(posedge hclk);
      if (sample_valid !== 1'b0) n++;
    end
    `CHK("no word", 0, n)
    // reset in mid run
    bus(1'b1, A_CTL, 32'h0000_000F, rd);
    repeat (40) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    `CHK("oe", 1'b0, mic_clock_out_oe)
    `CHK("pin", 1'b0, mic_clock_out_pin)
    hresetn <= 1'b1;
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0, rd);
      `CHK("reset read", re[i], rd)
    end
    summarize();
  end
endmodule

bind dmicfe_top dmicfe_top_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .mic_clock_out_pin(mic_clock_out_pin), .mic_clock_out_oe(mic_clock_out_oe),
  .adc_analog_en(adc_analog_en), .sample_data(sample_data),
  .sample_valid(sample_valid), .sample_ready(sample_ready));
